//--- tb/tpo_inverter_model.sv
// Purpose: Inverter gate drivers and switches
// Assumes: Active-high gate inputs
// Notes:   Fault pin low whenever the bench commands a fault
`timescale 1ns/10ps
module tpo_inverter_model (
    // Gates and bench command
    input  wire [5:0] gate,
    input  wire       fault_cmd,
    // Pin back to the device, shoot-through flag to the bench
    output wire       fault_trip_input_n,
    output wire       shoot_through
);
    // Pin returns high only once the fault is gone
    assign fault_trip_input_n = !fault_cmd;
    // Both switches of one leg on shorts the bus
    assign shoot_through = |(gate[4:0] & gate[5:1] & 5'h15);
endmodule // tpo_inverter_model

//--- tb/tpo_output_stage_tb.sv
// Purpose: Self-checking bench for the PWM output stage
// Assumes: Register indices from the shared defines
// Notes:   Register and sync checks, row table, then chop, shutdown and reset cases
`timescale 1ns/10ps
`include "tpo_defines.vh"
module tpo_output_stage_tb;
    typedef struct packed {
        logic [8:0] seg;
        logic [7:0] min;
        logic [7:0] duty;
        logic [5:0] raw;
        logic [5:0] exp;
    } tpo_row_t;
    tpo_row_t rows [0:10] = '{
        {9'h000, 8'd10, 8'd5, 6'h01, 6'h02}, {9'h000, 8'd10, 8'd13, 6'h01, 6'h01},
        {9'h000, 8'd10, 8'd188, 6'h02, 6'h01}, {9'h100, 8'd10, 8'd5, 6'h00, 6'h01},
        {9'h100, 8'd0, 8'd100, 6'h01, 6'h02}, {9'h080, 8'd0, 8'd100, 6'h04, 6'h08},
        {9'h040, 8'd0, 8'd100, 6'h20, 6'h10}, {9'h110, 8'd0, 8'd100, 6'h01, 6'h00},
        {9'h03f, 8'd0, 8'd100, 6'h3f, 6'h00}, {9'h001, 8'd0, 8'd100, 6'h3f, 6'h1f},
        {9'h000, 8'd0, 8'd100, 6'h15, 6'h15}};
    logic        clk, reset, read, write, fault_cmd, s, c;
    logic        timing_sync_raw, timing_second_half, timing_restart;
    logic [15:0] address, duty_phase_a;
    logic [31:0] writedata, q;
    logic [5:0]  timing_raw;
    wire  [31:0] readdata;
    wire         waitrequest, period_sync_pulse, trip_irq, trip_n, shoot;
    wire         ah, al, bh, bl, ch, cl;
    wire  [5:0]  gate = {cl, ch, bl, bh, al, ah};
    integer fails = 0, compares = 0, irq_cnt = 0, n, k, ones, run, mx, full;
    tpo_output_stage dut (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .timing_sync_raw(timing_sync_raw),
        .timing_second_half(timing_second_half),
        .timing_restart(timing_restart), .timing_raw(timing_raw),
        .period_count(16'd200), .duty_phase_a(duty_phase_a),
        .duty_phase_b(16'd100), .duty_phase_c(16'd100),
        .dead_time_count(16'd3), .fault_trip_input_n(trip_n),
        .phase_a_high(ah), .phase_a_low(al), .phase_b_high(bh),
        .phase_b_low(bl), .phase_c_high(ch), .phase_c_low(cl),
        .period_sync_pulse(period_sync_pulse), .trip_irq(trip_irq));
    tpo_inverter_model u_inv (.gate(gate), .fault_cmd(fault_cmd),
        .fault_trip_input_n(trip_n), .shoot_through(shoot));
    always #20 clk = ~clk;
    always @(posedge clk) if (trip_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    task chk(input [31:0] got, input [31:0] exp, input string nm);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task bus(input w, input [15:0] idx, input [31:0] d, output [31:0] r);
        @(posedge clk);
        address <= {idx[13:0], 2'b00};
        write <= w;
        read <= !w;
        writedata <= d;
        // Only the watchdog ends a wait that never gets its answer
        do @(posedge clk); while (waitrequest !== 1'b0);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task sync(input h, output p);
        @(posedge clk);
        timing_second_half <= h;
        timing_sync_raw <= 1'b1;
        @(posedge clk);
        timing_sync_raw <= 1'b0;
        @(posedge clk);
        p = period_sync_pulse;
        repeat (2) @(posedge clk);
    endtask
    task restart;
        @(posedge clk);
        timing_restart <= 1'b1;
        @(posedge clk);
        timing_restart <= 1'b0;
    endtask
    task chop(input [9:0] g);
        // Carrier set up before outputs are expected to switch
        bus(1, `TPO_IDX_GATE_CHOP, g, q);
        timing_raw <= 6'h03;
        sync(0, s);
        ones = 0; run = 0; mx = 0; full = 0;
        for (k = 0; k < 48; k++) begin
            @(posedge clk);
            c = g[8] ? ah : al;
            ones += c;
            run = c ? run + 1 : 0;
            if (run > mx) mx = run;
            full += g[8] ? al : ah;
        end
        chk(ones, 24, "chop_ones");
        chk(mx, 2 * (g[7:0] + 1), "chop_run");
        chk(full, 48, "unchopped");
    endtask
    task give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        give_verdict;
    end
    initial begin
        clk = 0; reset = 1; read = 0; write = 0; address = 0; writedata = 0;
        fault_cmd = 0; timing_sync_raw = 0; timing_second_half = 0;
        timing_restart = 0; timing_raw = 6'h15; duty_phase_a = 16'd100;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(0, `TPO_IDX_SEGMENT, 0, q); chk(q, 0, "seg");
        bus(0, `TPO_IDX_GATE_CHOP, 0, q); chk(q, 0, "chopreg");
        bus(1, `TPO_IDX_SEGMENT, 32'hffffffff, q);
        bus(0, `TPO_IDX_SEGMENT, 0, q); chk(q, 32'h1ff, "seg");
        bus(0, 16'h2070, 0, q); chk(q, 0, "unmapped");
        bus(1, `TPO_IDX_SEGMENT, 32'h100, q);
        timing_raw <= 6'h01;
        repeat (3) @(posedge clk); chk(gate, 6'h01, "gate");
        sync(1, s); chk(s, 0, "sync");
        chk(gate, 6'h01, "gate");
        bus(1, `TPO_IDX_MODE, 1, q);
        sync(1, s); chk(s, 1, "sync");
        chk(gate, 6'h02, "gate");
        bus(1, `TPO_IDX_MODE, 0, q);
        foreach (rows[i]) begin
            bus(1, `TPO_IDX_SEGMENT, rows[i].seg, q);
            bus(1, `TPO_IDX_MIN_PULSE, rows[i].min, q);
            duty_phase_a <= rows[i].duty;
            timing_raw <= rows[i].raw;
            sync(0, s);
            chk(gate, rows[i].exp, "gate");
            chk(shoot, |(rows[i].exp[4:0] & rows[i].exp[5:1] & 5'h15),
                "shoot");
        end
        chop(10'h102);
        chop(10'h200);
        bus(1, `TPO_IDX_GATE_CHOP, 0, q);
        timing_raw <= 6'h15;
        sync(0, s);
        n = irq_cnt;
        @(posedge clk);
        fault_cmd <= 1'b1;
        #1 chk(gate, 0, "gate");
        sync(0, s); chk(s, 0, "sync");
        chk(irq_cnt, n + 1, "irq");
        bus(0, `TPO_IDX_STATUS, 0, q); chk(q[0], 0, "pin");
        bus(0, `TPO_IDX_SW_SHUTDOWN, 0, q); chk(q[0], 0, "swflag");
        @(posedge clk);
        fault_cmd <= 1'b0;
        repeat (4) @(posedge clk);
        bus(0, `TPO_IDX_STATUS, 0, q); chk(q[0], 1, "pin");
        restart;
        sync(0, s); chk(gate, 6'h15, "gate");
        bus(1, `TPO_IDX_SW_SHUTDOWN, 1, q);
        repeat (2) @(posedge clk); chk(gate, 0, "gate");
        chk(irq_cnt, n + 2, "irq");
        bus(0, `TPO_IDX_SW_SHUTDOWN, 0, q); chk(q[0], 1, "swflag");
        bus(0, `TPO_IDX_SW_SHUTDOWN, 0, q); chk(q[0], 0, "swflag");
        restart;
        sync(0, s); chk(gate, 6'h15, "gate");
        // Reset in mid-run must clear what software has written
        bus(1, `TPO_IDX_SEGMENT, 32'h1ff, q);
        bus(1, `TPO_IDX_GATE_CHOP, 32'h3ff, q);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(0, `TPO_IDX_SEGMENT, 0, q); chk(q, 0, "seg");
        bus(0, `TPO_IDX_GATE_CHOP, 0, q); chk(q, 0, "chopreg");
        give_verdict;
    end
endmodule // tpo_output_stage_tb

//--- tb/tpo_props_properties.sv
// Purpose: Port checks for the PWM output stage
// Assumes: One clock, async active-high reset
// Notes:   Bound to the stage below the module
`timescale 1ns/10ps
module tpo_props (
    // Clock and bus
    input wire        clk,
    input wire        reset,
    input wire [15:0] address,
    input wire        read,
    input wire        write,
    input wire        waitrequest,
    // Timing and pin
    input wire        timing_sync_raw,
    input wire        fault_trip_input_n,
    // Outputs
    input wire        phase_a_high,
    input wire        phase_a_low,
    input wire        phase_b_high,
    input wire        phase_b_low,
    input wire        phase_c_high,
    input wire        phase_c_low,
    input wire        period_sync_pulse,
    input wire        trip_irq
);
    wire [5:0] g = {phase_c_low, phase_c_high, phase_b_low, phase_b_high,
                    phase_a_low, phase_a_high};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_trip_off: assert property (!fault_trip_input_n |-> g == 6'h00)
        else $error("gate on while tripped");
    a_sync_held: assert property (!fault_trip_input_n [*4] |-> !period_sync_pulse)
        else $error("sync pulse during trip");
    a_irq_once: assert property (trip_irq |=> !trip_irq)
        else $error("trip interrupt longer than one cycle");
    a_irq_dark: assert property (trip_irq |-> ##1 g == 6'h00)
        else $error("gate on after trip interrupt");
    a_sync_cause: assert property (period_sync_pulse |-> $past(timing_sync_raw))
        else $error("sync pulse without raw sync");
    a_sw_shut: assert property (write && !waitrequest && address == 16'h8184
        |-> ##[1:2] g == 6'h00)
        else $error("software trip left gate on");
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered");
    a_bus_one: assert property (!waitrequest |=> waitrequest)
        else $error("answer longer than one cycle");
    a_bus_idle: assert property (!(read || write) |=> waitrequest)
        else $error("answer without request");
    c_trip: cover property (trip_irq);
    c_sync: cover property (period_sync_pulse);
    c_read: cover property (read && !waitrequest);
endmodule // tpo_props

bind tpo_output_stage tpo_props u_props (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .waitrequest(waitrequest), .timing_sync_raw(timing_sync_raw),
    .fault_trip_input_n(fault_trip_input_n),
    .phase_a_high(phase_a_high), .phase_a_low(phase_a_low),
    .phase_b_high(phase_b_high), .phase_b_low(phase_b_low),
    .phase_c_high(phase_c_high), .phase_c_low(phase_c_low),
    .period_sync_pulse(period_sync_pulse), .trip_irq(trip_irq));

//--- verilog/tpo_defines.vh
// Purpose: Constants for the three-phase PWM output stage
// Assumes: Included by bare name from the design file
// Notes:   Offsets are register indices; byte address is index times four
`ifndef TPO_DEFINES_VH
`define TPO_DEFINES_VH

// Register indices (byte address = index * 4)
`define TPO_IDX_SW_SHUTDOWN   16'h2061
`define TPO_IDX_SEGMENT       16'h2062
`define TPO_IDX_GATE_CHOP     16'h2063
`define TPO_IDX_MIN_PULSE     16'h2064
`define TPO_IDX_STATUS        16'h2065
`define TPO_IDX_MODE          16'h2066
`define TPO_IDX_LSB           2

// Output-segment register layout
`define TPO_SEG_W             9
`define TPO_SEG_XOVER_A       8
`define TPO_SEG_XOVER_B       7
`define TPO_SEG_XOVER_C       6
`define TPO_SEG_DIS_LSB       0
`define TPO_SEG_RESET         9'h000

// Gate-chop register layout
`define TPO_GATE_W            10
`define TPO_GATE_DIV_MSB      7
`define TPO_GATE_DIV_LSB      0
`define TPO_GATE_CHOP_HIGH    8
`define TPO_GATE_CHOP_LOW     9
`define TPO_GATE_RESET        10'h000

// Status word layout
`define TPO_STAT_TRIP_LEVEL   0
`define TPO_STAT_SHUTDOWN     1
`define TPO_STAT_HALF         3

// Mode register layout
`define TPO_MODE_DOUBLE       0

// Misc reset values
`define TPO_MIN_PULSE_RESET   16'h0000
`define TPO_DIV_RESET         8'h00
`define TPO_PHASE_RESET       2'h0

`endif

//--- verilog/tpo_output_stage.v
// Purpose: Output stage of a three-phase center-based PWM controller
// Assumes: Timing unit on the same clock supplies raw signals and counts
// Notes:   Trip pin acts asynchronously on the output flops
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "tpo_defines.vh"

// Summary of operation
// - Minimum on-time is register value clock periods
// - Short pulse off for half, complement fully on
// - Nine-bit read/write output-segment control register
// - Bits 8,7,6 enable crossover on A,B,C
// - Crossover swaps high and low signals on pins
// - Reset clears all crossover bits
// - Bits 0-5 force their output off
// - Disables gate the signal after crossover
// - Reset clears all six disable bits
// - Segment latched at sync edge, midpoint too in double mode
// - Gate bits 8,9 chop high, low sides
// - Chop period is four times divider plus one
// - Reset clears whole gate-chop register
// - Trip low kills outputs, sync, raises interrupt
// - Status bit 0 shows trip input level
// - Write to software trip register shuts down
// - Read reports software or pin, then clears
// - Restart needs trip high and a timing_restart pulse
// - Sync once per period, twice in double
module tpo_output_stage #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset,
    // Avalon-MM slave
    input  wire [15:0]      address,
    input  wire             read,
    input  wire             write,
    input  wire [31:0]      writedata,
    output reg  [31:0]      readdata,
    output reg              waitrequest,
    // Timing unit
    input  wire             timing_sync_raw,
    input  wire             timing_second_half,
    input  wire             timing_restart,
    input  wire [5:0]       timing_raw,
    input  wire [CNT_W-1:0] period_count,
    input  wire [CNT_W-1:0] duty_phase_a,
    input  wire [CNT_W-1:0] duty_phase_b,
    input  wire [CNT_W-1:0] duty_phase_c,
    input  wire [CNT_W-1:0] dead_time_count,
    // Fault pin
    input  wire             fault_trip_input_n,
    // Gate drive outputs, bit order a_high,a_low,b_high,b_low,c_high,c_low
    output reg              phase_a_high,
    output reg              phase_a_low,
    output reg              phase_b_high,
    output reg              phase_b_low,
    output reg              phase_c_high,
    output reg              phase_c_low,
    // Sync and interrupts
    output reg              period_sync_pulse,
    output reg              trip_irq
);

    // Short-pulse test on a dead-time adjusted on-time
    function is_short;
        input [CNT_W-1:0] on_add;
        input [CNT_W-1:0] on_sub;
        input [CNT_W-1:0] min_on;
        reg   [CNT_W+1:0] diff;
        begin
            diff = {2'b00, on_add} - {2'b00, on_sub};
            // Negative on-time means zero on-time
            if (diff[CNT_W+1])
                is_short = (min_on != {CNT_W{1'b0}});
            else
                is_short = (diff < {2'b00, min_on});
        end
    endfunction

    // Register file
    reg  [`TPO_SEG_W-1:0]  seg_q;
    reg  [`TPO_SEG_W-1:0]  seg_act_q;
    reg  [`TPO_GATE_W-1:0] gate_q;
    reg  [CNT_W-1:0]       min_pulse_q;
    reg                    double_mode_q;
    reg                    sw_flag_q;
    reg                    shutdown_q;
    reg                    ack_q;

    // Trip synchroniser
    reg                    trip_meta_q;
    reg                    trip_lvl_q;

    // Sync edge and deletion state
    reg                    sync_prev_q;
    reg  [5:0]             del_q;
    reg  [5:0]             force_on_q;

    // Chop carrier
    reg  [7:0]             chop_cnt_q;
    reg  [1:0]             chop_phase_q;

    // Word index is two bits short of the byte address; pad on purpose
    wire [15:0] reg_idx   = {2'b00, address[15:`TPO_IDX_LSB]};
    wire        req       = read | write;
    wire        take      = req & ack_q;
    wire        do_write  = write & ack_q;
    wire        do_read   = read & ack_q;
    wire        sync_rise = timing_sync_raw & ~sync_prev_q;
    // Midpoint sync exists only in double update mode
    wire        sync_ok   = sync_rise & (double_mode_q | ~timing_second_half);
    wire        kill      = ~fault_trip_input_n | shutdown_q;
    wire        out_clr   = reset | kill;
    // Software trip register strobes, decoded once for every user
    wire        sw_trip_wr = do_write & (reg_idx == `TPO_IDX_SW_SHUTDOWN);
    wire        sw_trip_rd = do_read & (reg_idx == `TPO_IDX_SW_SHUTDOWN);

    // Bus handshake: one wait cycle, answer on the next edge
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q       <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            ack_q       <= req & ~ack_q;
            waitrequest <= ~(req & ~ack_q);
        end
    end

    // Read mux, registered with the handshake
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            case (reg_idx)
                `TPO_IDX_SW_SHUTDOWN:
                    readdata <= {31'h0000_0000, sw_flag_q};
                `TPO_IDX_SEGMENT:
                    readdata <= {23'h00_0000, seg_q};
                `TPO_IDX_GATE_CHOP:
                    readdata <= {22'h00_0000, gate_q};
                `TPO_IDX_MIN_PULSE:
                    readdata <= {{(32-CNT_W){1'b0}}, min_pulse_q};
                `TPO_IDX_STATUS: begin
                    readdata <= 32'h0000_0000;
                    readdata[`TPO_STAT_TRIP_LEVEL] <= trip_lvl_q;
                    readdata[`TPO_STAT_SHUTDOWN]   <= shutdown_q;
                    readdata[`TPO_STAT_HALF]       <= timing_second_half;
                end
                `TPO_IDX_MODE:
                    readdata <= {31'h0000_0000, double_mode_q};
                default:
                    readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software-written configuration
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            seg_q         <= `TPO_SEG_RESET;
            gate_q        <= `TPO_GATE_RESET;
            min_pulse_q   <= `TPO_MIN_PULSE_RESET;
            double_mode_q <= 1'b0;
        end else if (do_write) begin
            case (reg_idx)
                `TPO_IDX_SEGMENT:
                    seg_q <= writedata[`TPO_SEG_W-1:0];
                // Not interlocked: software programs this before running
                `TPO_IDX_GATE_CHOP:
                    gate_q <= writedata[`TPO_GATE_W-1:0];
                `TPO_IDX_MIN_PULSE:
                    min_pulse_q <= writedata[CNT_W-1:0];
                `TPO_IDX_MODE:
                    double_mode_q <= writedata[`TPO_MODE_DOUBLE];
                default: ;
            endcase
        end
    end

    // Trip pin synchroniser for status and shutdown latch
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            trip_meta_q <= 1'b1;
            trip_lvl_q  <= 1'b1;
        end else begin
            trip_meta_q <= fault_trip_input_n;
            trip_lvl_q  <= trip_meta_q;
        end
    end

    // Shutdown source flag and shutdown state
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_flag_q  <= 1'b0;
            shutdown_q <= 1'b0;
            trip_irq   <= 1'b0;
        end else begin
            // Set wins over the clearing read
            if (sw_trip_wr)
                sw_flag_q <= 1'b1;
            else if (sw_trip_rd)
                sw_flag_q <= 1'b0;
            if (sw_trip_wr)
                shutdown_q <= 1'b1;
            else if (~trip_lvl_q)
                shutdown_q <= 1'b1;
            else if (timing_restart)
                shutdown_q <= 1'b0;
            // One pulse when a shutdown begins
            trip_irq <= ~shutdown_q & (~trip_lvl_q | sw_trip_wr);
        end
    end

    // Sync output and active segment copy
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_prev_q       <= 1'b0;
            period_sync_pulse <= 1'b0;
            seg_act_q         <= `TPO_SEG_RESET;
        end else begin
            sync_prev_q       <= timing_sync_raw;
            // Width follows the raw pulse; suppressed while tripped
            period_sync_pulse <= timing_sync_raw & ~kill &
                                 (double_mode_q | ~timing_second_half);
            if (sync_ok)
                seg_act_q <= seg_q;
        end
    end

    // Minimum-pulse check, decided once per half period
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            del_q      <= 6'h00;
            force_on_q <= 6'h00;
        end else if (sync_rise) begin : chk
            reg [2:0] hs;
            reg [2:0] ls;
            integer   p;
            hs[0] = is_short(duty_phase_a, dead_time_count, min_pulse_q);
            hs[1] = is_short(duty_phase_b, dead_time_count, min_pulse_q);
            hs[2] = is_short(duty_phase_c, dead_time_count, min_pulse_q);
            ls[0] = is_short(period_count - duty_phase_a, dead_time_count,
                             min_pulse_q);
            ls[1] = is_short(period_count - duty_phase_b, dead_time_count,
                             min_pulse_q);
            ls[2] = is_short(period_count - duty_phase_c, dead_time_count,
                             min_pulse_q);
            for (p = 0; p < 3; p = p + 1) begin
                // High-side deletion takes priority if both are short
                del_q[2*p]        <= hs[p];
                force_on_q[2*p+1] <= hs[p];
                del_q[2*p+1]      <= ls[p] & ~hs[p];
                force_on_q[2*p]   <= ls[p] & ~hs[p];
            end
        end
    end

    // Chop carrier: quarter counter of divider+1 clocks, four quarters
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            chop_cnt_q   <= `TPO_DIV_RESET;
            chop_phase_q <= `TPO_PHASE_RESET;
        end else if (chop_cnt_q >= gate_q[`TPO_GATE_DIV_MSB:`TPO_GATE_DIV_LSB]) begin
            chop_cnt_q   <= `TPO_DIV_RESET;
            chop_phase_q <= chop_phase_q + 2'h1;
        end else begin
            chop_cnt_q   <= chop_cnt_q + 8'h01;
        end
    end

    wire carrier = chop_phase_q[1];

    // Deletion, crossover, disable and chop per output
    wire [5:0] shaped;
    wire [5:0] routed;
    wire [5:0] gated;
    wire [2:0] xover = {seg_act_q[`TPO_SEG_XOVER_C],
                        seg_act_q[`TPO_SEG_XOVER_B],
                        seg_act_q[`TPO_SEG_XOVER_A]};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pair
            assign shaped[2*g]   = (timing_raw[2*g] & ~del_q[2*g]) |
                                   force_on_q[2*g];
            assign shaped[2*g+1] = (timing_raw[2*g+1] & ~del_q[2*g+1]) |
                                   force_on_q[2*g+1];
            assign routed[2*g]   = xover[g] ? shaped[2*g+1]
                                            : shaped[2*g];
            assign routed[2*g+1] = xover[g] ? shaped[2*g]
                                            : shaped[2*g+1];
        end
    endgenerate

    // Disable bits 0..5 map c_low,c_high,b_low,b_high,a_low,a_high
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_out
            wire dis  = seg_act_q[`TPO_SEG_DIS_LSB + 5 - g];
            wire high = (g % 2) == 0;
            wire chop = high ? gate_q[`TPO_GATE_CHOP_HIGH]
                             : gate_q[`TPO_GATE_CHOP_LOW];
            assign gated[g] = routed[g] & ~dis &
                              (~chop | carrier);
        end
    endgenerate

    // Output flops cleared at once by the trip pin, no clock needed
    always @(posedge clk or posedge out_clr) begin
        if (out_clr) begin
            phase_a_high <= 1'b0;
            phase_a_low  <= 1'b0;
            phase_b_high <= 1'b0;
            phase_b_low  <= 1'b0;
            phase_c_high <= 1'b0;
            phase_c_low  <= 1'b0;
        end else begin
            phase_a_high <= gated[0];
            phase_a_low  <= gated[1];
            phase_b_high <= gated[2];
            phase_b_low  <= gated[3];
            phase_c_high <= gated[4];
            phase_c_low  <= gated[5];
        end
    end

endmodule // tpo_output_stage
